// [rtl/slb_pkg.sv]
package slb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SHORT_PRESS_S   = 3;
    localparam int unsigned RESTART_PRESS_S = 15;
    localparam int unsigned DEBOUNCE_US     = 10_000;
    localparam int unsigned BLINK_MS        = 250;
    localparam int unsigned ACT_BLINK_MS    = 50;
    localparam int unsigned SHORT_CYC       = SHORT_PRESS_S * CLK_HZ;
    localparam int unsigned RESTART_CYC     = RESTART_PRESS_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
    localparam int unsigned ACT_BLINK_CYC   = ACT_BLINK_MS * (CLK_HZ / 1000);
    localparam int unsigned HOLD_W          = 31;
    localparam int unsigned PICKUP_N        = 3;
    localparam int unsigned TIMING_W        = 10;

    // ------------------------------------------------------------------
    // Status lamp colours
    // ------------------------------------------------------------------
    localparam logic [1:0] COL_OFF    = 2'h0;
    localparam logic [1:0] COL_GREEN  = 2'h1;
    localparam logic [1:0] COL_RED    = 2'h2;
    localparam logic [1:0] COL_YELLOW = 2'h3;

    typedef struct packed {
        logic ack_warnings;
        logic ack_error_alarms;
        logic restart;
    } slb_ack_t;

    typedef struct packed {
        logic [1:0]          status_color;
        logic                firing;
        logic [PICKUP_N-1:0] pickup;
        logic                general_purpose_output;
    } slb_lamps_t;

endpackage : slb_pkg

// [rtl/slb_pulse_stretch.sv]
`timescale 1ns/10ps
`default_nettype none
module slb_pulse_stretch
    import slb_pkg::*;
#(
    parameter int unsigned LEN = 1
) (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    // Activity
    input  wire logic edge_in,
    output var  logic lamp_out
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        lamp_next;

    assign cnt_next  = edge_in ? LEN : ((cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0);
    assign lamp_next = (cnt_next != 32'h0);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg  <= 32'h0;
            lamp_out <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lamp_out <= lamp_next;
        end
    end

endmodule : slb_pulse_stretch
`default_nettype wire

// [rtl/slb_status_led_button.sv]
// How it works
// - Status lamp blinks green while running without error or warning.
// - Status lamp steady red on error, yellow on warning.
// - Firing lamp follows ignition activity, forced off during self test.
// - Each of three pickup lamps blinks on activity of its pickup.
// - General purpose output lamp on exactly while that output is active.
// - Potentiometer timing passed only when configuration enable is set.
// - Press under 3 s acknowledges all existing warnings.
// - Press of 3 s to 15 s, no pickups, error present: clear error and alarms.
// - Press over 3 s acknowledges warnings unless the hold triggered a restart.
// - Hold over 15 s with no pickups restarts the controller.
`timescale 1ns/10ps
`default_nettype none
module slb_status_led_button
    import slb_pkg::*;
#(
    parameter int unsigned DEB_LIM     = DEBOUNCE_CYC,
    parameter int unsigned SHORT_LIM   = SHORT_CYC,
    parameter int unsigned RESTART_LIM = RESTART_CYC,
    parameter int unsigned BLINK_LIM   = BLINK_CYC,
    parameter int unsigned ACT_LIM     = ACT_BLINK_CYC
) (
    // Clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    // Controller state
    input  wire logic                running_in,
    input  wire logic                error_in,
    input  wire logic                warning_in,
    input  wire logic                ignition_active_in,
    input  wire logic                self_test_in,
    input  wire logic                general_purpose_output_in,
    input  wire logic [PICKUP_N-1:0] pickup_in,
    input  wire logic                pickups_detected_in,
    // Potentiometer
    input  wire logic                pot_enable_in,
    input  wire logic [TIMING_W-1:0] pot_value_in,
    // Service button, raw pin, active high when pressed
    input  wire logic                service_ack_button_in,
    // Lamps
    output var  slb_lamps_t          lamps_out,
    // Actions, one-cycle pulses
    output var  slb_ack_t            ack_out,
    // Timing adjustment
    output var  logic                pot_valid_out,
    output var  logic [TIMING_W-1:0] pot_timing_out
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic                btn_s1_reg;
    logic                btn_s2_reg;
    logic [PICKUP_N-1:0] pk_s1_reg;
    logic [PICKUP_N-1:0] pk_s2_reg;
    logic [PICKUP_N-1:0] pk_s3_reg;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            btn_s1_reg <= 1'b0;
            btn_s2_reg <= 1'b0;
            pk_s1_reg  <= '0;
            pk_s2_reg  <= '0;
            pk_s3_reg  <= '0;
        end else begin
            btn_s1_reg <= service_ack_button_in;
            btn_s2_reg <= btn_s1_reg;
            pk_s1_reg  <= pickup_in;
            pk_s2_reg  <= pk_s1_reg;
            pk_s3_reg  <= pk_s2_reg;
        end
    end

    // ------------------------------------------------------------------
    // Debounce and hold timer
    // ------------------------------------------------------------------
    logic              btn_db_reg;
    logic              btn_db_next;
    logic [HOLD_W-1:0] deb_reg;
    logic [HOLD_W-1:0] deb_next;
    logic [HOLD_W-1:0] hold_reg;
    logic [HOLD_W-1:0] hold_next;
    logic              restart_done_reg;
    logic              restart_done_next;
    logic              release_w;
    logic              band_short_w;
    logic              band_long_w;
    logic              restart_hit_w;

    assign deb_next    = (btn_s2_reg == btn_db_reg) ? '0 :
                         ((deb_reg == HOLD_W'(DEB_LIM)) ? '0 : deb_reg + 1'b1);
    assign btn_db_next = (deb_reg == HOLD_W'(DEB_LIM)) ? btn_s2_reg : btn_db_reg;
    assign hold_next   = btn_db_reg ? ((hold_reg == '1) ? hold_reg : hold_reg + 1'b1) : '0;
    assign release_w   = btn_db_reg && !btn_db_next;
    assign band_short_w = release_w && (hold_reg < HOLD_W'(SHORT_LIM));
    assign band_long_w  = release_w && (hold_reg >= HOLD_W'(SHORT_LIM))
                          && !restart_done_reg && !restart_hit_w;
    assign restart_hit_w = btn_db_reg && !restart_done_reg
                           && (hold_reg > HOLD_W'(RESTART_LIM)) && !pickups_detected_in;
    assign restart_done_next = btn_db_reg ? (restart_done_reg || restart_hit_w) : 1'b0;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            btn_db_reg       <= 1'b0;
            deb_reg          <= '0;
            hold_reg         <= '0;
            restart_done_reg <= 1'b0;
        end else begin
            btn_db_reg       <= btn_db_next;
            deb_reg          <= deb_next;
            hold_reg         <= hold_next;
            restart_done_reg <= restart_done_next;
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge actions
    // ------------------------------------------------------------------
    slb_ack_t ack_next;

    always_comb begin
        ack_next = '0;
        ack_next.ack_warnings     = band_short_w || band_long_w;
        ack_next.ack_error_alarms = band_long_w && !pickups_detected_in && error_in;
        ack_next.restart          = restart_hit_w;
    end

    // ------------------------------------------------------------------
    // Lamps
    // ------------------------------------------------------------------
    logic [31:0]         blink_cnt_reg;
    logic                blink_reg;
    logic                blink_tick_w;
    logic [PICKUP_N-1:0] pk_edge_w;
    logic [PICKUP_N-1:0] pk_lamp_w;
    slb_lamps_t          lamps_next;

    assign blink_tick_w = (blink_cnt_reg == BLINK_LIM - 1);
    assign pk_edge_w    = pk_s2_reg & ~pk_s3_reg;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            blink_cnt_reg <= 32'h0;
            blink_reg     <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_tick_w ? 32'h0 : blink_cnt_reg + 32'h1;
            blink_reg     <= blink_tick_w ? !blink_reg : blink_reg;
        end
    end

    for (genvar i = 0; i < PICKUP_N; i++) begin : g_pk
        slb_pulse_stretch #(
            .LEN (ACT_LIM)
        ) u_stretch (
            .sys_clk_in (sys_clk_in),
            .sys_rst_in (sys_rst_in),
            .edge_in    (pk_edge_w[i]),
            .lamp_out   (pk_lamp_w[i])
        );
    end

    always_comb begin
        lamps_next = '0;
        if (error_in) begin
            lamps_next.status_color = COL_RED;
        end else if (warning_in) begin
            lamps_next.status_color = COL_YELLOW;
        end else if (running_in && blink_reg) begin
            lamps_next.status_color = COL_GREEN;
        end else begin
            lamps_next.status_color = COL_OFF;
        end
        lamps_next.firing = ignition_active_in && !self_test_in;
        lamps_next.pickup = pk_lamp_w;
        lamps_next.general_purpose_output = general_purpose_output_in;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lamps_out      <= '0;
            ack_out        <= '0;
            pot_valid_out  <= 1'b0;
            pot_timing_out <= '0;
        end else begin
            lamps_out      <= lamps_next;
            ack_out        <= ack_next;
            pot_valid_out  <= pot_enable_in;
            pot_timing_out <= pot_enable_in ? pot_value_in : '0;
        end
    end

endmodule : slb_status_led_button
`default_nettype wire

// [testbench/slb_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module slb_checker
    import slb_pkg::*;
(
    // Clock and reset
    input wire logic                sys_clk_in,
    input wire logic                sys_rst_in,
    // Watched inputs
    input wire logic                running_in,
    input wire logic                error_in,
    input wire logic                warning_in,
    input wire logic                ignition_active_in,
    input wire logic                self_test_in,
    input wire logic                general_purpose_output_in,
    input wire logic [PICKUP_N-1:0] pickup_in,
    input wire logic                pickups_detected_in,
    input wire logic                pot_enable_in,
    input wire logic [TIMING_W-1:0] pot_value_in,
    // Watched outputs
    input wire slb_lamps_t          lamps_out,
    input wire slb_ack_t            ack_out,
    input wire logic                pot_valid_out,
    input wire logic [TIMING_W-1:0] pot_timing_out
);
default clocking cb @(posedge sys_clk_in); endclocking
default disable iff (sys_rst_in);
sequence s_live; !$past(sys_rst_in); endsequence
sequence s_lit0; ##[3:5] lamps_out.pickup[0]; endsequence
property p_red; s_live ##0 $past(error_in) |-> lamps_out.status_color == COL_RED; endproperty
property p_yel; s_live ##0 $past(!error_in && warning_in) |-> lamps_out.status_color == COL_YELLOW;
endproperty
property p_grn; s_live ##0 $past(running_in && !error_in && !warning_in)
    |-> lamps_out.status_color inside {COL_GREEN, COL_OFF}; endproperty
property p_fire; s_live |-> lamps_out.firing == $past(ignition_active_in && !self_test_in);
endproperty
property p_gpo; s_live |-> lamps_out.general_purpose_output == $past(general_purpose_output_in);
endproperty
property p_pot; s_live |-> pot_valid_out == $past(pot_enable_in)
    && pot_timing_out == ($past(pot_enable_in) ? $past(pot_value_in) : '0); endproperty
property p_pick; $rose(pickup_in[0]) |-> s_lit0; endproperty
property p_pulse; ack_out.ack_warnings |=> !ack_out.ack_warnings; endproperty
property p_both; ack_out.ack_error_alarms |-> ack_out.ack_warnings; endproperty
property p_rst; ack_out.restart |-> !$past(pickups_detected_in) && !ack_out.ack_warnings;
endproperty
property p_err; ack_out.ack_error_alarms |-> $past(error_in) && !$past(pickups_detected_in);
endproperty
property p_rpulse; ack_out.restart |=> !ack_out.restart; endproperty
a_red: assert property (p_red) else $error("status not red");
a_yel: assert property (p_yel) else $error("status not yellow");
a_grn: assert property (p_grn) else $error("status not green blink");
a_fire: assert property (p_fire) else $error("firing lamp wrong");
a_gpo: assert property (p_gpo) else $error("output lamp wrong");
a_pot: assert property (p_pot) else $error("timing value wrong");
a_pick: assert property (p_pick) else $error("pickup lamp not lit");
a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
a_both: assert property (p_both) else $error("alarm clear without ack");
a_rst: assert property (p_rst) else $error("restart not allowed");
a_err: assert property (p_err) else $error("error clear not allowed");
a_rpulse: assert property (p_rpulse) else $error("restart longer than one cycle");
endmodule : slb_checker
bind slb_status_led_button slb_checker u_chk (.sys_clk_in, .sys_rst_in, .running_in, .error_in,
    .warning_in, .ignition_active_in, .self_test_in, .general_purpose_output_in, .pickup_in,
    .pickups_detected_in, .pot_enable_in, .pot_value_in, .lamps_out, .ack_out, .pot_valid_out,
    .pot_timing_out);
`default_nettype wire

// [testbench/slb_operator.sv]
`timescale 1ns/10ps
`default_nettype none
module slb_operator (
    // Clock
    input  wire logic sys_clk_in,
    // Button pin, high while pressed
    output var  logic button_out
);
initial button_out = 1'b0;
// Holds the button for a number of cycles, changing only just after an edge.
task automatic press(input int cycles);
    @(posedge sys_clk_in);
    button_out <= 1'b1;
    repeat (cycles) @(posedge sys_clk_in);
    button_out <= 1'b0;
endtask : press
endmodule : slb_operator
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb
    import slb_pkg::*;
;
// Shortened timing so that every press band fits in the run.
localparam int unsigned DEB_T     = 8;
localparam int unsigned SHORT_T   = 60;
localparam int unsigned RESTART_T = 200;
localparam int unsigned BLINK_T   = 16;
localparam int unsigned ACT_T     = 40;
logic                sys_clk_in, sys_rst_in, running_in, error_in, warning_in, self_test_in;
logic                ignition_active_in, general_purpose_output_in, pickups_detected_in;
logic                pot_enable_in, service_ack_button_in, pot_valid_out;
logic [PICKUP_N-1:0] pickup_in;
logic [TIMING_W-1:0] pot_value_in, pot_timing_out;
slb_lamps_t          lamps_out;
slb_ack_t            ack_out;
int                  mismatches, n_compared, acks, greens, press_len;
logic                press_err, press_pk;
slb_ack_t            last_ack;
slb_status_led_button #(.DEB_LIM(DEB_T), .SHORT_LIM(SHORT_T), .RESTART_LIM(RESTART_T),
    .BLINK_LIM(BLINK_T), .ACT_LIM(ACT_T))
    DUT (.sys_clk_in, .sys_rst_in, .running_in, .error_in, .warning_in,
    .ignition_active_in, .self_test_in, .general_purpose_output_in, .pickup_in,
    .pickups_detected_in, .pot_enable_in, .pot_value_in, .service_ack_button_in, .lamps_out,
    .ack_out, .pot_valid_out, .pot_timing_out);
slb_operator OP (.sys_clk_in, .button_out(service_ack_button_in));
initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
end
always @(posedge sys_clk_in) begin
    if (!sys_rst_in && ack_out !== '0) begin
        acks++;
        last_ack <= ack_out;
    end
end
task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask : final_report
task automatic check_model;
    int col;
    col = error_in ? 2 : warning_in ? 3 : running_in ? 1 : 0;
    if (col == 0) `CHK(lamps_out.status_color, COL_OFF)
    if (col == 1) `CHK(lamps_out.status_color inside {COL_GREEN, COL_OFF}, 1'b1)
    if (col > 1) `CHK(lamps_out.status_color, 2'(col))
    `CHK(lamps_out.firing, ignition_active_in & ~self_test_in)
    `CHK(lamps_out.general_purpose_output, general_purpose_output_in)
    `CHK(pot_timing_out, pot_enable_in ? pot_value_in : {TIMING_W{1'b0}})
    `CHK(pot_valid_out, pot_enable_in)
endtask : check_model
function automatic slb_ack_t model_ack(input int len, input logic err, input logic pk);
    slb_ack_t a;
    a = '0;
    if (len > RESTART_T && !pk) begin
        a.restart = 1'b1;
    end else begin
        a.ack_warnings     = 1'b1;
        a.ack_error_alarms = (len > SHORT_T) && err && !pk;
    end
    return a;
endfunction : model_ack
task automatic press_case;
    @(posedge sys_clk_in);
    error_in            <= press_err;
    pickups_detected_in <= press_pk;
    #1;
    acks = 0;
    OP.press(press_len);
    repeat (DEB_T + 12) @(posedge sys_clk_in);
    #1;
endtask : press_case
initial begin
    {running_in, error_in, warning_in, ignition_active_in, self_test_in} = '0;
    {general_purpose_output_in, pickups_detected_in, pot_enable_in} = '0;
    pickup_in = '0;
    pot_value_in = '0;
    sys_rst_in = 1'b1;
    mismatches = 0;
    n_compared = 0;
    acks = 0;
    void'($urandom(74383));
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < PICKUP_N; i++) begin
        @(posedge sys_clk_in) pickup_in[i] <= 1'b1;
        for (int k = 0; lamps_out.pickup[i] !== 1'b1; k++) begin
            if (k == 8) begin
                mismatches++;
                final_report();
            end
            @(posedge sys_clk_in);
            #1;
        end
        `CHK(lamps_out.pickup, PICKUP_N'((1 << (i + 1)) - 1))
    end
    repeat (ACT_T + 8) @(posedge sys_clk_in);
    #1;
    `CHK(lamps_out.pickup, {PICKUP_N{1'b0}})
    for (int n = 0; n < 400; n++) begin
        @(posedge sys_clk_in);
        {running_in, error_in, warning_in, ignition_active_in} <= 4'($urandom);
        {self_test_in, general_purpose_output_in, pot_enable_in, pickups_detected_in}
            <= 4'($urandom);
        pot_value_in <= TIMING_W'($urandom);
        @(posedge sys_clk_in);
        #1;
        check_model();
    end
    @(posedge sys_clk_in);
    {running_in, error_in, warning_in} <= 3'b100;
    @(posedge sys_clk_in);
    greens = 0;
    for (int n = 0; n < 4 * BLINK_T; n++) begin
        @(posedge sys_clk_in);
        #1;
        if (lamps_out.status_color == COL_GREEN) greens++;
    end
    `CHK(greens, 2 * BLINK_T)
    acks = 0;
    OP.press(1 + $urandom % (DEB_T - 1));
    repeat (DEB_T + 12) @(posedge sys_clk_in);
    #1;
    `CHK(acks, 0)
    for (int n = 0; n < 8; n++) begin
        press_err = n[0];
        press_pk  = (n >= 6) ? n[0] : n[1];
        press_len = (n < 2) ? 20 + $urandom % 30 :
                    (n < 6) ? 80 + $urandom % 80 : 230 + $urandom % 40;
        press_case();
        `CHK(acks, 1)
        if (n < 2) `CHK(last_ack, model_ack(press_len, press_err, press_pk))
        if (n >= 2 && n < 6) `CHK(last_ack, model_ack(press_len, press_err, press_pk))
        if (n >= 6) `CHK(last_ack, model_ack(press_len, press_err, press_pk))
    end
    @(posedge sys_clk_in) sys_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    `CHK({lamps_out, ack_out, pot_valid_out, pot_timing_out}, '0)
    final_report();
end
endmodule : tb
`default_nettype wire
